// ==== design/rpd_top.v ====
// Purpose: three-phase reactive power datapath with calibration registers
// Assumes: voltage and current samples synchronous to mclk
// Notes:   registers reached on a simple word port; no interrupt logic
// Function
// - total reactive power is formed for each of the three phases from all harmonics.
// - each current is shifted by 90 degrees and multiplied with its voltage.
// - reported power is the dc part of the product, kept by low-pass averaging.
// - instantaneous total power per phase is readable, scaled down by sixteen.
// - optional fundamental power path per phase, fed from the first harmonic only.
// - fundamental output settles within 375 ms at 63% and 875 ms at full scale.
// - each phase has a total-path gain and a separate fundamental-path gain.
// - average power is filter output times one plus signed gain over 2^23.
// - gain 0xc00000 halves the output and 0x400000 raises it by half.
// - gain words are 32 bits with top eight zero, sign-extended to 28 bits inside.
// - signed 24-bit offsets exist per phase for total and fundamental power.
// - offset words are 32 bits with top eight zero, sign-extended to 28 bits inside.
// - powers are computed once per 125 us sample period.
`include "rpd_defines.vh"
module rpd_top
(
	input  wire        mclk,
	input  wire        sys_rst,
	input  wire [71:0] volt_in,
	input  wire [71:0] cur_in,
	input  wire [71:0] fund_volt_in,
	input  wire [71:0] fund_cur_in,
	input  wire        reg_wr,
	input  wire        reg_rd,
	input  wire [3:0]  reg_addr,
	input  wire [31:0] reg_wdata,
	output reg  [31:0] reg_rdata_ff,
	output reg         sample_stb_ff,
	output wire [83:0] total_var_avg,
	output wire [83:0] fund_var_avg,
	output reg         fund_settled_ff
);
	localparam [31:0] SAMPLE_CYC_FULL = `RPD_SAMPLE_CYC;
	localparam [14:0] SAMPLE_CYC = SAMPLE_CYC_FULL[14:0];
	localparam [31:0] SETTLE_SAMPLES = `RPD_SETTLE_FS_MS * 8;
	reg  [23:0] cal_ff [0:11];
	reg         fund_en_ff;
	reg  [14:0] div_ff;
	reg  [31:0] settle_ff;
	wire [83:0] tot_inst;
	wire [83:0] fund_avg_raw;
	integer     i;
	// ****************************************************************
	// sample strobe, one per 125 us
	// ****************************************************************
	always @(posedge mclk)
	begin
		if (sys_rst)
		begin
			div_ff        <= 15'h0000;
			sample_stb_ff <= 1'b0;
		end
		else
		begin
			sample_stb_ff <= (div_ff == SAMPLE_CYC - 15'h0001);
			if (div_ff == SAMPLE_CYC - 15'h0001)
				div_ff <= 15'h0000;
			else
				div_ff <= div_ff + 15'h0001;
		end
	end
	// ****************************************************************
	// calibration registers
	// ****************************************************************
	always @(posedge mclk)
	begin
		if (sys_rst)
		begin
			for (i = 0; i < 12; i = i + 1)
				cal_ff[i] <= `RPD_REG_RESET;
			fund_en_ff <= 1'b0;
		end
		else if (reg_wr)
		begin
			if (reg_addr < `RPD_IDX_A_INST)
				cal_ff[reg_addr] <= reg_wdata[23:0];
			else if (reg_addr == `RPD_IDX_FUND_EN)
				fund_en_ff <= reg_wdata[0];
		end
	end
	// ****************************************************************
	// read port
	// ****************************************************************
	always @(posedge mclk)
	begin
		if (sys_rst)
			reg_rdata_ff <= 32'h00000000;
		else if (reg_rd)
		begin
			if (reg_addr < `RPD_IDX_A_INST)
				reg_rdata_ff <= {8'h00, cal_ff[reg_addr]};
			else if (reg_addr == `RPD_IDX_A_INST)
				reg_rdata_ff <= {{4{tot_inst[27]}}, tot_inst[27:0]};
			else if (reg_addr == `RPD_IDX_B_INST)
				reg_rdata_ff <= {{4{tot_inst[55]}}, tot_inst[55:28]};
			else if (reg_addr == `RPD_IDX_C_INST)
				reg_rdata_ff <= {{4{tot_inst[83]}}, tot_inst[83:56]};
			else
				reg_rdata_ff <= {31'h00000000, fund_en_ff};
		end
	end
	// ****************************************************************
	// per-phase datapaths
	// ****************************************************************
	genvar p;
	generate
		for (p = 0; p < 3; p = p + 1)
		begin : g_ph
			wire [23:0] cq_tot;
			wire [23:0] cq_fund;
			wire [23:0] tg = cal_ff[p];
			wire [23:0] fg = cal_ff[p + 3];
			wire [23:0] to = cal_ff[p + 6];
			wire [23:0] fo = cal_ff[p + 9];
			rpd_quad_shift u_qt
			(
				.mclk    (mclk),
				.sys_rst (sys_rst),
				.smp_stb (sample_stb_ff),
				.din     (cur_in[p*24 +: 24]),
				.dout_ff (cq_tot)
			);
			rpd_quad_shift u_qf
			(
				.mclk    (mclk),
				.sys_rst (sys_rst),
				.smp_stb (sample_stb_ff),
				.din     (fund_cur_in[p*24 +: 24]),
				.dout_ff (cq_fund)
			);
			rpd_phase_path u_tot
			(
				.mclk    (mclk),
				.sys_rst (sys_rst),
				.smp_stb (sample_stb_ff),
				.volt    (volt_in[p*24 +: 24]),
				.cur_q   (cq_tot),
				.ofs     ({{4{to[23]}}, to}),
				.gain    ({{4{tg[23]}}, tg}),
				.inst_ff (tot_inst[p*28 +: 28]),
				.avg_ff  (total_var_avg[p*28 +: 28])
			);
			rpd_phase_path u_fund
			(
				.mclk    (mclk),
				.sys_rst (sys_rst),
				.smp_stb (sample_stb_ff),
				.volt    (fund_volt_in[p*24 +: 24]),
				.cur_q   (cq_fund),
				.ofs     ({{4{fo[23]}}, fo}),
				.gain    ({{4{fg[23]}}, fg}),
				.inst_ff (),
				.avg_ff  (fund_avg_raw[p*28 +: 28])
			);
			assign fund_var_avg[p*28 +: 28] = fund_en_ff ? fund_avg_raw[p*28 +: 28]
				: 28'h0000000;
		end
	endgenerate
	// ****************************************************************
	// fundamental settling flag
	// ****************************************************************
	always @(posedge mclk)
	begin
		if (sys_rst || !fund_en_ff)
		begin
			settle_ff       <= 32'h00000000;
			fund_settled_ff <= 1'b0;
		end
		else if (sample_stb_ff)
		begin
			if (settle_ff >= SETTLE_SAMPLES - 32'h00000001)
				fund_settled_ff <= 1'b1;
			else
				settle_ff <= settle_ff + 32'h00000001;
		end
	end
endmodule

// ==== design/rpd_defines.vh ====
// Purpose: constants for the reactive power datapath
// Assumes: 200 MHz mclk, 8 kHz power sample rate
// Notes:   register indices are local word addresses
`ifndef RPD_DEFINES_VH
`define RPD_DEFINES_VH
// ****************************************************************
// register indices
// ****************************************************************
`define RPD_IDX_A_TOT_GAIN   4'h0
`define RPD_IDX_B_TOT_GAIN   4'h1
`define RPD_IDX_C_TOT_GAIN   4'h2
`define RPD_IDX_A_FUND_GAIN  4'h3
`define RPD_IDX_B_FUND_GAIN  4'h4
`define RPD_IDX_C_FUND_GAIN  4'h5
`define RPD_IDX_A_TOT_OFS    4'h6
`define RPD_IDX_B_TOT_OFS    4'h7
`define RPD_IDX_C_TOT_OFS    4'h8
`define RPD_IDX_A_FUND_OFS   4'h9
`define RPD_IDX_B_FUND_OFS   4'ha
`define RPD_IDX_C_FUND_OFS   4'hb
`define RPD_IDX_A_INST       4'hc
`define RPD_IDX_B_INST       4'hd
`define RPD_IDX_C_INST       4'he
`define RPD_IDX_FUND_EN      4'hf
`define RPD_REG_RESET        24'h000000
// ****************************************************************
// numeric formats
// ****************************************************************
`define RPD_CAL_W            24
`define RPD_DSP_W            28
`define RPD_GAIN_FRAC        23
`define RPD_INST_SHIFT       4
`define RPD_FULL_SCALE_POWER 28'd33516139
// ****************************************************************
// timing
// ****************************************************************
`define RPD_CLK_HZ           200000000
`define RPD_SAMPLE_US        125
`define RPD_SAMPLE_CYC       ((`RPD_CLK_HZ / 1000000) * `RPD_SAMPLE_US)
`define RPD_LPF_SHIFT        4'd9
`define RPD_SETTLE_63_MS     375
`define RPD_SETTLE_FS_MS     875
`endif

// ==== design/rpd_quad_shift.v ====
// Purpose: 90 degree shift of a current sample stream
// Assumes: one new sample per sample strobe
// Notes:   first-order leaky integrator approximation at the line frequency
`include "rpd_defines.vh"
module rpd_quad_shift
(
	input  wire               mclk,
	input  wire               sys_rst,
	input  wire               smp_stb,
	input  wire signed [23:0] din,
	output reg  signed [23:0] dout_ff
);
	// ****************************************************************
	// negated leaky integrator: lags by 90 degrees, sign flip gives +90
	// ****************************************************************
	reg  signed [27:0] acc_ff;
	wire signed [27:0] nxt_acc;
	assign nxt_acc = acc_ff + $signed({{4{din[23]}}, din}) - (acc_ff >>> 6);
	always @(posedge mclk)
	begin
		if (sys_rst)
		begin
			acc_ff  <= 28'sh0000000;
			dout_ff <= 24'sh000000;
		end
		else if (smp_stb)
		begin
			acc_ff  <= nxt_acc;
			dout_ff <= 24'sh000000 - acc_ff[27:4];
		end
	end
endmodule

// ==== design/rpd_phase_path.v ====
// Purpose: one phase, one power type: product, offset, averaging, gain
// Assumes: calibration values already sign-extended to 28 bits
// Notes:   averaging is a first-order low-pass in shift form
`include "rpd_defines.vh"
module rpd_phase_path
(
	input  wire               mclk,
	input  wire               sys_rst,
	input  wire               smp_stb,
	input  wire signed [23:0] volt,
	input  wire signed [23:0] cur_q,
	input  wire signed [27:0] ofs,
	input  wire signed [27:0] gain,
	output reg  signed [27:0] inst_ff,
	output reg  signed [27:0] avg_ff
);
	reg  signed [27:0] lpf_ff;
	wire signed [47:0] prod;
	wire signed [27:0] inst_raw;
	wire signed [27:0] inst_ofs;
	wire signed [27:0] nxt_lpf;
	wire signed [56:0] scaled;
	// ****************************************************************
	// product and offset
	// ****************************************************************
	assign prod     = volt * cur_q;
	assign inst_raw = prod[47:20];
	assign inst_ofs = inst_raw + ofs;
	// ****************************************************************
	// averaging and gain
	// ****************************************************************
	assign nxt_lpf  = lpf_ff + ((inst_ofs - lpf_ff) >>> `RPD_LPF_SHIFT);
	assign scaled   = lpf_ff * ($signed({gain[27], gain}) + 29'sh0800000);
	always @(posedge mclk)
	begin
		if (sys_rst)
		begin
			lpf_ff  <= 28'sh0000000;
			inst_ff <= 28'sh0000000;
			avg_ff  <= 28'sh0000000;
		end
		else if (smp_stb)
		begin
			lpf_ff  <= nxt_lpf;
			inst_ff <= inst_ofs >>> `RPD_INST_SHIFT;
			avg_ff  <= scaled[50:23];
		end
	end
endmodule

// ==== test/rpd_props.sv ====
// Purpose: port checker for rpd_top
// Assumes: sync reset sys_rst
// Notes:   bound after the module
module rpd_props
(
	input wire        mclk,
	input wire        sys_rst,
	input wire        reg_wr,
	input wire        reg_rd,
	input wire [3:0]  reg_addr,
	input wire [31:0] reg_wdata,
	input wire [31:0] reg_rdata_ff,
	input wire        sample_stb_ff,
	input wire [83:0] total_var_avg,
	input wire [83:0] fund_var_avg,
	input wire        fund_settled_ff
);
	default clocking @(posedge mclk); endclocking
	default disable iff (sys_rst);
	reg [15:0] cnt_ff;
	reg        seen_ff;
	reg        en_ff;
	reg        fen_ff;
	reg [12:0] nstb_ff;
	always @(posedge mclk)
	begin
		cnt_ff <= (sys_rst || sample_stb_ff) ? 16'h0000 : cnt_ff + 16'h0001;
		seen_ff <= !sys_rst && (seen_ff || sample_stb_ff);
		en_ff <= !sys_rst && (en_ff || (reg_wr && reg_addr == 4'hf && reg_wdata[0]));
		fen_ff <= sys_rst ? 1'b0 : (reg_wr && reg_addr == 4'hf) ? reg_wdata[0] : fen_ff;
		nstb_ff <= (sys_rst || !fen_ff) ? 13'h0000
			: (sample_stb_ff && nstb_ff < 13'd6999) ? nstb_ff + 13'h0001 : nstb_ff;
	end
	// ****
	// properties
	// ****
	property p_rd_hold; !$past(reg_rd) && !$past(sys_rst) |-> $stable(reg_rdata_ff); endproperty
	a_rd_hold: assert property (p_rd_hold) else $error("read data moved");
	property p_cal_rb; reg_wr && reg_addr < 4'hc ##1 reg_rd && reg_addr == $past(reg_addr)
		|=> reg_rdata_ff == ($past(reg_wdata, 2) & 32'h00ffffff); endproperty
	a_cal_rb: assert property (p_cal_rb) else $error("readback wrong");
	property p_cal_pad; reg_rd && reg_addr < 4'hc |=> reg_rdata_ff[31:24] == 8'h00; endproperty
	a_cal_pad: assert property (p_cal_pad) else $error("pad not zero");
	property p_inst_sx; reg_rd && reg_addr >= 4'hc && reg_addr <= 4'he
		|=> reg_rdata_ff[31:28] == {4{reg_rdata_ff[27]}}; endproperty
	a_inst_sx: assert property (p_inst_sx) else $error("inst not extended");
	property p_stb_per; seen_ff |-> sample_stb_ff == (cnt_ff == 16'h61a7); endproperty
	a_stb_per: assert property (p_stb_per) else $error("sample period");
	property p_stb_one; sample_stb_ff |=> !sample_stb_ff [*8]; endproperty
	a_stb_one: assert property (p_stb_one) else $error("strobe width");
	property p_avg_hold; !sample_stb_ff && !$past(sample_stb_ff) && !$past(sys_rst)
		|-> $stable(total_var_avg)
		&& ($stable(fund_var_avg) || $past(reg_wr && reg_addr == 4'hf)); endproperty
	a_avg_hold: assert property (p_avg_hold) else $error("avg off strobe");
	property p_fund_off; !en_ff |-> fund_var_avg == 84'h0 && !fund_settled_ff; endproperty
	a_fund_off: assert property (p_fund_off) else $error("fund while off");
	property p_settle_early; fen_ff && nstb_ff < 13'd6999 |-> !fund_settled_ff; endproperty
	a_settle_early: assert property (p_settle_early) else $error("settled too early");
	c_stb: cover property (sample_stb_ff);
	c_inst: cover property (reg_rd && reg_addr == 4'hc);
	c_fund: cover property (en_ff && sample_stb_ff);
endmodule
bind rpd_top rpd_props i_rpd_props
(
	.mclk(mclk), .sys_rst(sys_rst), .reg_wr(reg_wr), .reg_rd(reg_rd),
	.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata_ff(reg_rdata_ff),
	.sample_stb_ff(sample_stb_ff), .total_var_avg(total_var_avg),
	.fund_var_avg(fund_var_avg), .fund_settled_ff(fund_settled_ff)
);

// ==== test/tb.sv ====
// Purpose: self-checking bench for rpd_top
// Assumes: 200 MHz mclk
// Notes:   waits two sample periods
module tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic               mclk = 1'b0;
	logic               sys_rst = 1'b1;
	logic [71:0]        volt_in = 72'h0;
	logic [71:0]        cur_in = 72'h0;
	logic [71:0]        fund_volt_in = 72'h0;
	logic [71:0]        fund_cur_in = 72'h0;
	wire                fund_settled_ff;
	logic               reg_wr = 1'b0;
	logic               reg_rd = 1'b0;
	logic [3:0]         reg_addr = 4'h0;
	logic [31:0]        reg_wdata = 32'h0;
	wire  [31:0]        reg_rdata_ff;
	wire                sample_stb_ff;
	wire  [83:0]        total_var_avg;
	wire  [83:0]        fund_var_avg;
	int                 errors = 0;
	int                 total_checks = 0;
	int                 cyc = 0;
	logic [31:0]        d;
	logic [31:0]        v;
	logic signed [27:0] p0, p1, p2;
	logic [23:0]        cal [12] = '{24'h0, 24'h400000, 24'hc00000, 24'h0, 24'h400000,
		24'hc00000, 24'h800001, 24'h800001, 24'h800001, 24'h7fffff, 24'h7fffff, 24'h7fffff};
	always #2.5 mclk = ~mclk;
	rpd_top i_rpd_top
	(
		.mclk(mclk), .sys_rst(sys_rst), .volt_in(volt_in), .cur_in(cur_in),
		.fund_volt_in(fund_volt_in), .fund_cur_in(fund_cur_in), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata_ff(reg_rdata_ff),
		.sample_stb_ff(sample_stb_ff), .total_var_avg(total_var_avg),
		.fund_var_avg(fund_var_avg), .fund_settled_ff(fund_settled_ff)
	);
	// ****
	// tasks
	// ****
	task chk(input logic [31:0] s, input logic [31:0] e);
		total_checks++;
		if (s !== e)
		begin
			errors++;
			$display("ERROR %0t: seen %h expected %h", $time, s, e);
		end
	endtask
	task near(input logic signed [27:0] s, input logic signed [27:0] e);
		logic signed [27:0] df;
		df = s - e;
		chk({31'h0, df >= -28'sh2 && df <= 28'sh2}, 32'h1);
	endtask
	task wr(input logic [3:0] a, input logic [31:0] w);
		reg_wr = 1'b1;
		reg_addr = a;
		reg_wdata = w;
		@(posedge mclk) #1;
		reg_wr = 1'b0;
	endtask
	task rd(input logic [3:0] a);
		reg_rd = 1'b1;
		reg_addr = a;
		@(posedge mclk) #1;
		reg_rd = 1'b0;
		@(posedge mclk) #1;
		d = reg_rdata_ff;
	endtask
	task stop_test;
		$display("checks %0d errors %0d", total_checks, errors);
		if (errors == 0 && total_checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	always @(posedge mclk)
	begin
		cyc <= cyc + 1;
		if (cyc == 60000)
		begin
			errors++;
			stop_test;
		end
	end
	// ****
	// tests
	// ****
	initial
	begin
		repeat (6) @(posedge mclk);
		#1 sys_rst = 1'b0;
		volt_in = {3{24'h400000}};
		cur_in = {3{24'h400000}};
		fund_volt_in = {3{24'h400000}};
		fund_cur_in = {3{24'h400000}};
		for (int i = 0; i < 16; i++)
		begin
			if (i < 12 || i == 15)
			begin
				rd(i[3:0]);
				chk(d, 32'h0);
			end
		end
		wr(4'hf, 32'h1);
		rd(4'hf);
		chk(d, 32'h1);
		for (int i = 0; i < 12; i++)
		begin
			wr(i[3:0], {8'ha5, cal[i]});
			rd(i[3:0]);
			chk(d, {8'h00, cal[i]});
		end
		for (int i = 12; i < 15; i++)
		begin
			rd(i[3:0]);
			v = d;
			wr(i[3:0], 32'h00123456);
			rd(i[3:0]);
			chk(d, v);
		end
		repeat (2)
		begin
			@(posedge mclk) #1;
			while (sample_stb_ff !== 1'b1)
				@(posedge mclk) #1;
		end
		repeat (4) @(posedge mclk);
		#1;
		p0 = total_var_avg[27:0];
		p1 = total_var_avg[55:28];
		p2 = total_var_avg[83:56];
		near(p1, p0 + (p0 >>> 1));
		near(p2, p0 >>> 1);
		p0 = fund_var_avg[27:0];
		p1 = fund_var_avg[55:28];
		p2 = fund_var_avg[83:56];
		chk({31'h0, p0 > 28'sh0}, 32'h1);
		near(p1, p0 + (p0 >>> 1));
		near(p2, p0 >>> 1);
		chk({31'h0, fund_settled_ff}, 32'h0);
		rd(4'hc);
		chk(d, 32'hfff80000);
		stop_test;
	end
endmodule
